// file: core/ste_encoder.sv
// Time code encoder: emulation marks and level-shift / modulated frames
`timescale 1ns/1ps
module ste_encoder
  import ste_pkg::*;
#(
  parameter int MS_CYC = CAR_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sec_pulse,
  input wire ste_time_t time_in,
  input wire logic sync_ok,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic lw_mark,
  output logic tc_dcls,
  output logic tc_am_mark,
  output logic tc_carrier
);

  localparam int MW = $clog2(MS_CYC);
  localparam int PW = 10;

  if (MS_CYC < 4) begin : g_chk
    $error("ste_encoder: MS_CYC too small");
  end

  // Variant decoding
  function automatic logic has_year(input ste_fmt_t f);
    return f inside {FMT_B6, FMT_B7, FMT_1344, FMT_C37, FMT_AFNOR};
  endfunction : has_year

  function automatic logic has_sbs(input ste_fmt_t f);
    return f inside {FMT_B3, FMT_B7, FMT_1344, FMT_C37, FMT_AFNOR};
  endfunction : has_sbs

  function automatic logic is_ext(input ste_fmt_t f);
    return f inside {FMT_1344, FMT_C37};
  endfunction : is_ext

  // Reset release
  logic [1:0] rst_pipe_q;
  wire logic rst_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_q[1];

  // Millisecond tick and 1 kHz carrier, phased to the second
  logic [MW-1:0] ms_cnt_q;
  logic carrier_q;
  wire logic ms_tick;

  assign ms_tick = (ms_cnt_q == MW'(MS_CYC - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
      carrier_q <= 1'b0;
    end else begin
      ms_cnt_q <= (sec_pulse || ms_tick) ? '0 : ms_cnt_q + 1'b1;
      carrier_q <= !sec_pulse && (ms_cnt_q < MW'(MS_CYC / 2));
    end
  end

  assign tc_carrier = carrier_q;

  // Software registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [TZ_W-1:0] tz_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] stat_val;
  wire logic [DATA_W-1:0] rd_val;
  wire ste_fmt_t fmt_sel;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      tz_q <= TZ_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_q <= reg_wdata[CTRL_W-1:0];
      end else if (reg_addr == REG_TZ) begin
        tz_q <= reg_wdata[TZ_W-1:0];
      end
    end
  end

  // Unknown codes fall back to the plain variant
  assign fmt_sel = (ctrl_q[2:0] > 3'(FMT_AFNOR)) ? FMT_B2 : ste_fmt_t'(ctrl_q[2:0]);

  // Frame snapshot
  ste_time_t cur_q;
  ste_fmt_t fmt_f_q;
  logic [TZ_W-1:0] tz_f_q;
  logic [3:0] tfom_q;
  logic synced_q;
  logic [6:0] idx_q;
  wire logic tc_end;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= '0;
      fmt_f_q <= FMT_B2;
      tz_f_q <= TZ_RST;
      tfom_q <= TFOM_FAILED;
      synced_q <= 1'b0;
      idx_q <= '0;
    end else begin
      if (sync_ok) begin
        synced_q <= 1'b1;
      end
      if (sec_pulse) begin
        cur_q <= time_in;
        fmt_f_q <= fmt_sel;
        tz_f_q <= tz_q;
        if (ctrl_q[CTRL_TFOM_OFF]) begin
          tfom_q <= TFOM_LOCKED;
        end else if (synced_q || sync_ok) begin
          tfom_q <= TFOM_LOCKED;
        end else begin
          tfom_q <= TFOM_FAILED;
        end
        idx_q <= '0;
      end else if (tc_end && idx_q != 7'(FRAME_BITS - 1)) begin
        idx_q <= idx_q + 7'h01;
      end
    end
  end

  // Time code frame content
  logic [FRAME_BITS-1:0] irig_v;

  always_comb begin
    irig_v = '0;
    irig_v[POS_SEC +: 4] = cur_q.sec_bcd[3:0];
    irig_v[POS_SEC + TENS_OFS +: 3] = cur_q.sec_bcd[6:4];
    irig_v[POS_MIN +: 4] = cur_q.min_bcd[3:0];
    irig_v[POS_MIN + TENS_OFS +: 3] = cur_q.min_bcd[6:4];
    irig_v[POS_HOUR +: 4] = cur_q.hour_bcd[3:0];
    irig_v[POS_HOUR + TENS_OFS +: 2] = cur_q.hour_bcd[5:4];
    irig_v[POS_DOY +: 4] = cur_q.doy_bcd[3:0];
    irig_v[POS_DOY + TENS_OFS +: 4] = cur_q.doy_bcd[7:4];
    irig_v[POS_DOY + HUND_OFS +: 2] = cur_q.doy_bcd[9:8];
    if (has_year(fmt_f_q)) begin
      irig_v[POS_YEAR +: 4] = cur_q.year_bcd[3:0];
      irig_v[POS_YEAR + TENS_OFS +: 4] = cur_q.year_bcd[7:4];
    end
    if (is_ext(fmt_f_q)) begin
      irig_v[POS_LSP] = cur_q.ls_pend;
      irig_v[POS_LS] = 1'b0;
      irig_v[POS_DSP] = cur_q.dst_pend;
      irig_v[POS_DST] = cur_q.dst;
      irig_v[POS_TZS] = tz_f_q[TZ_SIGN] ^ (fmt_f_q == FMT_C37);
      irig_v[POS_TZH +: 4] = tz_f_q[TZ_HRS_LSB +: 4];
      irig_v[POS_TZ_HALF] = tz_f_q[TZ_HALF];
      irig_v[POS_TFOM +: 4] = tfom_q;
      irig_v[POS_PAR] = ^irig_v[POS_PAR-1:0];
    end else if (fmt_f_q == FMT_AFNOR) begin
      irig_v[AF_DAY +: 6] = cur_q.day_bcd;
      irig_v[AF_MON +: 5] = cur_q.mon_bcd;
      irig_v[AF_DOW +: 3] = cur_q.dow;
    end
    if (has_sbs(fmt_f_q)) begin
      irig_v[POS_SBS_LO +: 9] = cur_q.sbs[8:0];
      irig_v[POS_SBS_HI +: 8] = cur_q.sbs[16:9];
    end
  end

  wire logic tc_is_mark;
  wire ste_sym_t irig_sym;

  assign tc_is_mark = (idx_q == 7'h00) || (idx_q % 7'(MARK_EVERY) == 7'(MARK_AT));
  assign irig_sym = tc_is_mark ? SYM_MARK : (irig_v[idx_q] ? SYM_ONE : SYM_ZERO);

  // Emulation minute content, local time
  logic [63:0] lw_v;
  wire logic [5:0] lw_idx;
  wire ste_sym_t lw_sym;

  assign lw_idx = 6'(cur_q.sec_bcd[6:4]) * 6'h0a + 6'(cur_q.sec_bcd[3:0]);

  always_comb begin
    lw_v = '0;
    lw_v[D_DSP] = cur_q.dst_pend;
    lw_v[D_DST] = cur_q.dst;
    lw_v[D_DST + 1] = !cur_q.dst;
    lw_v[D_LSP] = cur_q.ls_pend;
    lw_v[D_START] = 1'b1;
    lw_v[D_MIN +: 7] = cur_q.min_bcd;
    lw_v[D_MIN + 7] = ^cur_q.min_bcd;
    lw_v[D_HOUR +: 6] = cur_q.hour_bcd;
    lw_v[D_HOUR + 6] = ^cur_q.hour_bcd;
    lw_v[D_DAY +: 6] = cur_q.day_bcd;
    lw_v[D_DOW +: 3] = cur_q.dow;
    lw_v[D_MON +: 5] = cur_q.mon_bcd;
    lw_v[D_YEAR +: 8] = cur_q.year_bcd;
    lw_v[D_PAR] = ^lw_v[D_PAR-1:D_DAY];
  end

  // Second 59 stays silent to flag the minute
  assign lw_sym = (lw_idx == 6'(DCF_SKIP_SEC)) ? SYM_NONE :
                  (lw_v[lw_idx] ? SYM_ONE : SYM_ZERO);

  // Pulse generators
  wire logic tc_lvl;
  wire logic [PW-1:0] tc_pos;
  wire logic lw_lvl;
  wire logic [PW-1:0] lw_pos;

  ste_shaper #(
    .CELL(CELL_MS),
    .W0(IRIG_ZERO_MS),
    .W1(IRIG_ONE_MS),
    .WM(IRIG_MARK_MS),
    .PW(PW)
  ) u_tc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(ms_tick),
    .sync(sec_pulse),
    .sym(irig_sym),
    .level(tc_lvl),
    .pos(tc_pos),
    .cell_end(tc_end)
  );

  // Runs from the first sec_pulse, no wait for synchronisation
  ste_shaper #(
    .CELL(MS_PER_SEC),
    .W0(DCF_ZERO_MS),
    .W1(DCF_ONE_MS),
    .WM(0),
    .PW(PW)
  ) u_lw (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(ms_tick),
    .sync(sec_pulse),
    .sym(lw_sym),
    .level(lw_lvl),
    .pos(lw_pos),
    .cell_end()
  );

  assign lw_mark = lw_lvl;
  assign tc_dcls = tc_lvl;
  assign tc_am_mark = tc_lvl;

  // Register read port
  always_comb begin
    stat_val = '0;
    stat_val[STAT_SYNCED] = synced_q;
    stat_val[STAT_LW] = lw_lvl;
    stat_val[STAT_DCLS] = tc_lvl;
    stat_val[STAT_IDX_LSB +: 7] = idx_q;
  end

  assign rd_val = (reg_addr == REG_CTRL) ? DATA_W'(ctrl_q) :
                  (reg_addr == REG_TZ) ? DATA_W'(tz_q) :
                  (reg_addr == REG_STAT) ? stat_val : '0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_val : '0;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_lw_start;
    sec_pulse ##1 !sec_pulse |-> ##1 (lw_mark == (lw_idx != 6'(DCF_SKIP_SEC)));
  endproperty
  a_lw_start: assert property (p_lw_start)
    else $error("emulation mark wrong at second start");

  property p_lw_width;
    $fell(lw_mark) |-> lw_pos == PW'((lw_sym == SYM_ONE) ? DCF_ONE_MS : DCF_ZERO_MS);
  endproperty
  a_lw_width: assert property (p_lw_width)
    else $error("emulation mark width wrong");

  property p_tc_width;
    $fell(tc_dcls) |-> tc_pos == PW'((irig_sym == SYM_ONE) ? IRIG_ONE_MS :
                                     (irig_sym == SYM_MARK) ? IRIG_MARK_MS : IRIG_ZERO_MS);
  endproperty
  a_tc_width: assert property (p_tc_width)
    else $error("level shift pulse width wrong");

  property p_same;
    tc_dcls == tc_am_mark;
  endproperty
  a_same: assert property (p_same)
    else $error("modulated and level codes differ");

  property p_markers;
    (idx_q == 7'd49 || idx_q == 7'd59 || idx_q == 7'd69) |-> irig_sym == SYM_MARK;
  endproperty
  a_markers: assert property (p_markers)
    else $error("position marker missing");

  property p_no_delete;
    irig_v[POS_LS] == 1'b0;
  endproperty
  a_no_delete: assert property (p_no_delete)
    else $error("leap deletion signalled");

  property p_c37;
    fmt_f_q == FMT_C37 |-> irig_v[POS_TZS] != tz_f_q[TZ_SIGN];
  endproperty
  a_c37: assert property (p_c37)
    else $error("offset sign not inverted");

  property p_parity;
    is_ext(fmt_f_q) |-> (^irig_v[POS_PAR:0]) == 1'b0;
  endproperty
  a_parity: assert property (p_parity)
    else $error("control field parity odd");

  property p_tfom_fail;
    sec_pulse && !ctrl_q[CTRL_TFOM_OFF] && !synced_q && !sync_ok |=> tfom_q == TFOM_FAILED;
  endproperty
  a_tfom_fail: assert property (p_tfom_fail)
    else $error("merit not failed before sync");

  property p_tfom_off;
    sec_pulse && ctrl_q[CTRL_TFOM_OFF] |=> tfom_q == 4'h0;
  endproperty
  a_tfom_off: assert property (p_tfom_off)
    else $error("merit not forced to zero");

  property p_latch;
    !sec_pulse |=> $stable(cur_q);
  endproperty
  a_latch: assert property (p_latch)
    else $error("frame values changed mid-frame");

endmodule : ste_encoder

// file: core/ste_pkg.sv
// Constants, types and the rule summary for the serial time code encoder
// How it works
// - Emulation mark rises at each second start
// - Mark lasts 100 ms for zero, 200 ms for one
// - No mark in second 59
// - Seconds 21 to 58 carry date, time, parity
// - Marks follow configured local time and announcements
// - Emulation output runs from the first epoch, no wait for sync
// - Markers 49/59/69, year BCD at 50-58
// - Bit 60 leap pending, bit 61 insertion zero
// - Leap deletion is never signalled
// - Bit 62 shows daylight change pending
// - Bit 63 set during daylight saving
// - Bit 64 offset sign, bits 65-68 hours
// - Bit 70 flags extra half hour
// - Bits 71-74 figure of merit, 0 locked
// - Merit cleared at first synchronisation
// - Bit 75 parity over preceding bits
// - Level-shift and modulated codes carry same content
// - 100 bits per second, 1 kHz carrier
// - Variant picks year and binary seconds content
// - Extended variant adds control-field date, zone, flags
// - C37 variant inverts the offset sign
// - AFNOR variant carries full date and seconds
// - Carrier cell: 2, 5 or 8 mark cycles
// - Merit is 1111 until first synchronisation
// - Test setting forces merit field to zero
package ste_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int CARRIER_HZ = 1000;
  localparam int CAR_CYC = CLK_HZ / CARRIER_HZ;
  localparam int MS_PER_SEC = 1000;
  localparam int BIT_RATE = 100;
  localparam int CELL_MS = MS_PER_SEC / BIT_RATE;
  localparam int FRAME_BITS = 100;
  localparam int MARK_EVERY = 10;
  localparam int MARK_AT = 9;

  localparam int IRIG_ZERO_MS = 2;
  localparam int IRIG_ONE_MS = 5;
  localparam int IRIG_MARK_MS = 8;
  localparam int DCF_ZERO_MS = 100;
  localparam int DCF_ONE_MS = 200;
  localparam int DCF_SKIP_SEC = 59;

  // Frame field positions
  localparam int TENS_OFS = 5;
  localparam int HUND_OFS = 10;
  localparam int POS_SEC = 1;
  localparam int POS_MIN = 10;
  localparam int POS_HOUR = 20;
  localparam int POS_DOY = 30;
  localparam int POS_YEAR = 50;
  localparam int POS_LSP = 60;
  localparam int POS_LS = 61;
  localparam int POS_DSP = 62;
  localparam int POS_DST = 63;
  localparam int POS_TZS = 64;
  localparam int POS_TZH = 65;
  localparam int POS_TZ_HALF = 70;
  localparam int POS_TFOM = 71;
  localparam int POS_PAR = 75;
  localparam int POS_SBS_LO = 80;
  localparam int POS_SBS_HI = 90;
  localparam int AF_DAY = 60;
  localparam int AF_MON = 70;
  localparam int AF_DOW = 76;

  // Emulation minute positions
  localparam int D_DSP = 16;
  localparam int D_DST = 17;
  localparam int D_LSP = 19;
  localparam int D_START = 20;
  localparam int D_MIN = 21;
  localparam int D_HOUR = 29;
  localparam int D_DAY = 36;
  localparam int D_DOW = 42;
  localparam int D_MON = 45;
  localparam int D_YEAR = 50;
  localparam int D_PAR = 58;

  localparam logic [3:0] TFOM_LOCKED = 4'h0;
  localparam logic [3:0] TFOM_FAILED = 4'hf;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 4;
  localparam int TZ_W = 6;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TZ = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [TZ_W-1:0] TZ_RST = 6'h00;
  localparam int CTRL_TFOM_OFF = 3;
  localparam int TZ_SIGN = 0;
  localparam int TZ_HRS_LSB = 1;
  localparam int TZ_HALF = 5;
  localparam int STAT_SYNCED = 0;
  localparam int STAT_LW = 1;
  localparam int STAT_DCLS = 2;
  localparam int STAT_IDX_LSB = 8;

  typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_MARK, SYM_NONE} ste_sym_t;

  typedef enum logic [2:0] {
    FMT_B2, FMT_B3, FMT_B6, FMT_B7, FMT_1344, FMT_C37, FMT_AFNOR
  } ste_fmt_t;

  typedef struct packed {
    logic [6:0] sec_bcd;
    logic [6:0] min_bcd;
    logic [5:0] hour_bcd;
    logic [9:0] doy_bcd;
    logic [5:0] day_bcd;
    logic [4:0] mon_bcd;
    logic [2:0] dow;
    logic [7:0] year_bcd;
    logic [16:0] sbs;
    logic dst;
    logic dst_pend;
    logic ls_pend;
  } ste_time_t;

endpackage : ste_pkg

// file: core/ste_shaper.sv
// Pulse width shaper for one symbol per cell
`timescale 1ns/1ps
module ste_shaper
  import ste_pkg::*;
#(
  parameter int CELL = CELL_MS,
  parameter int W0 = IRIG_ZERO_MS,
  parameter int W1 = IRIG_ONE_MS,
  parameter int WM = IRIG_MARK_MS,
  parameter int PW = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic sync,
  input wire ste_sym_t sym,
  output logic level,
  output logic [PW-1:0] pos,
  output logic cell_end
);

  localparam int MAXW = (W1 > WM) ? W1 : WM;

  if (CELL >= 2 ** PW || MAXW >= CELL || W0 >= W1) begin : g_chk
    $error("ste_shaper: widths do not fit the cell");
  end

  logic [PW-1:0] pos_q;
  logic run_q;
  logic level_q;
  wire logic [PW-1:0] width;

  // Width in ticks for the current symbol
  assign width = (sym == SYM_ZERO) ? PW'(W0) :
                 (sym == SYM_ONE) ? PW'(W1) :
                 (sym == SYM_MARK) ? PW'(WM) : '0;
  assign cell_end = run_q && tick && !sync && (pos_q == PW'(CELL - 1));
  assign level = level_q;
  assign pos = pos_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= '0;
      run_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      level_q <= run_q && (pos_q < width);
      if (sync) begin
        pos_q <= '0;
        run_q <= 1'b1;
      end else if (tick && run_q) begin
        pos_q <= cell_end ? '0 : pos_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_level_bound;
    level_q |-> pos_q <= PW'(MAXW);
  endproperty
  a_level_bound: assert property (p_level_bound)
    else $error("pulse runs past longest width");

endmodule : ste_shaper

// file: tb/ste_rx_model.sv
// Receiver model: decodes level-shift symbols, carrier and emulation marks
`timescale 1ns/1ps
module ste_rx_model
  import ste_pkg::*;
#(
  parameter int MS = 8
) (
  input wire logic core_clk,
  input wire logic tc_dcls,
  input wire logic tc_am_mark,
  input wire logic tc_carrier,
  input wire logic lw_mark,
  output logic [99:0] bits,
  output logic [99:0] mk,
  output logic [7:0] sym_bad,
  output logic am_bad,
  output logic car_bad,
  output logic [15:0] lw_len,
  output logic [7:0] lw_n
);
  localparam int W0 = IRIG_ZERO_MS * MS;
  localparam int W1 = IRIG_ONE_MS * MS;
  localparam int WM = IRIG_MARK_MS * MS;
  int hi = 0;
  int lo = 0;
  int cc = 0;
  int lwh = 0;
  int idx = 0;
  logic prev_m = 1'b0;
  logic car_p = 1'b0;
  initial begin
    bits = '0;
    mk = '0;
    sym_bad = 8'h00;
    am_bad = 1'b0;
    car_bad = 1'b0;
    lw_len = 16'h0000;
    lw_n = 8'h00;
  end
  always @(posedge core_clk) begin
    int i;
    am_bad <= am_bad | (tc_am_mark !== tc_dcls);
    car_p <= tc_carrier;
    if (tc_carrier && !car_p) begin
      if (cc > 0 && cc < 100 && cc != MS) car_bad <= 1'b1;
      cc <= 1;
    end else begin
      // Period is judged only from the first rising edge on
      if (cc > 0) cc <= cc + 1;
    end
    if (lw_mark) begin
      lwh <= lwh + 1;
    end else if (lwh != 0) begin
      lw_len <= 16'(lwh);
      lw_n <= lw_n + 8'h01;
      lwh <= 0;
    end
    if (tc_dcls) begin
      hi <= hi + 1;
      lo <= 0;
    end else begin
      lo <= lo + 1;
      if (lo > 100) idx <= 0;
      if (hi != 0) begin
        // Two markers in a row open a frame
        i = (hi == WM && prev_m) ? 0 : idx;
        if (i < 100) begin
          bits[i] <= (hi == W1);
          mk[i] <= (hi == WM);
        end
        if (hi != W0 && hi != W1 && hi != WM) sym_bad <= sym_bad + 8'h01;
        prev_m <= (hi == WM);
        idx <= i + 1;
        hi <= 0;
      end
    end
  end
endmodule : ste_rx_model

// file: tb/ste_encoder_tb_top.sv
// Self-checking bench for the time code encoder
`timescale 1ns/1ps
module ste_encoder_tb_top
  import ste_pkg::*;
;
  localparam int MS = 8;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic sec_pulse = 1'b0;
  ste_time_t time_in = '0;
  logic sync_ok = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic lw_mark, tc_dcls, tc_am_mark, tc_carrier, am_bad, car_bad;
  logic [99:0] bits, mk, emk;
  logic [7:0] sym_bad, lw_n;
  logic [15:0] lw_len;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  ste_time_t tt;

  always #12.5 core_clk = ~core_clk;

  ste_encoder #(.MS_CYC(MS)) u_ste_encoder (.core_clk(core_clk), .resetn(resetn),
    .sec_pulse(sec_pulse), .time_in(time_in), .sync_ok(sync_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lw_mark(lw_mark), .tc_dcls(tc_dcls), .tc_am_mark(tc_am_mark), .tc_carrier(tc_carrier));

  ste_rx_model #(.MS(MS)) u_ste_rx_model (.core_clk(core_clk), .tc_dcls(tc_dcls),
    .tc_am_mark(tc_am_mark), .tc_carrier(tc_carrier), .lw_mark(lw_mark), .bits(bits),
    .mk(mk), .sym_bad(sym_bad), .am_bad(am_bad), .car_bad(car_bad), .lw_len(lw_len),
    .lw_n(lw_n));

  task automatic chk(input logic [99:0] g, input logic [99:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge core_clk);
  endtask : rd

  // One second: epoch, then time_in cleared to show it is latched once
  // Tail write keeps epochs exactly one second and whole carrier periods apart
  task automatic frame(input ste_time_t t, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    time_in <= t;
    sec_pulse <= 1'b1;
    @(posedge core_clk);
    sec_pulse <= 1'b0;
    time_in <= '0;
    #1 chk(tc_dcls, 1'b0);
    @(posedge core_clk);
    #1 chk(tc_dcls, 1'b1);
    chk(lw_mark, t.sec_bcd != 7'h59);
    repeat (7996) @(posedge core_clk);
    wr(a, d);
  endtask : frame

  task automatic t_regs();
    chk({lw_mark, tc_dcls, tc_carrier, reg_rdata}, '0);
    rd(REG_CTRL, 16'(CTRL_RST));
    rd(REG_TZ, 16'(TZ_RST));
    rd(REG_STAT, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(REG_TZ, 16'hffff);
    rd(REG_TZ, 16'h003f);
    wr(4'h7, 16'h1234);
    rd(4'h7, 16'h0000);
    wr(REG_CTRL, 16'hfff8);
    rd(REG_CTRL, 16'h0008);
    wr(REG_CTRL, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_lw();
    logic [7:0] n;
    tt = '0;
    tt.dst_pend = 1'b1;
    tt.sec_bcd = 7'h16;
    frame(tt, REG_TZ, 16'h002b);
    chk(lw_len, 16'(DCF_ONE_MS * MS));
    tt = '0;
    tt.sec_bcd = 7'h17;
    frame(tt, 4'h7, 16'h0000);
    chk(lw_len, 16'(DCF_ZERO_MS * MS));
    n = lw_n;
    tt.sec_bcd = 7'h59;
    frame(tt, 4'h7, 16'h0000);
    chk(lw_n, n);
    $display("test emulation done");
  endtask : t_lw

  task automatic t_var();
    ste_fmt_t f;
    logic y, s;
    for (int k = 0; k < 5; k++) begin
      f = ste_fmt_t'(k == 4 ? 6 : k);
      y = (f == FMT_B6) || (f == FMT_B7) || (f == FMT_AFNOR);
      s = (f == FMT_B3) || (f == FMT_B7) || (f == FMT_AFNOR);
      tt = '0;
      tt.year_bcd = 8'h17;
      tt.sbs = 17'h00155;
      tt.sec_bcd = 7'h21;
      // Next variant code goes in now and is latched at the next epoch
      frame(tt, REG_CTRL, k == 4 ? 16'h0004 : 16'(k == 3 ? 6 : k + 1));
      chk(mk, emk);
      chk(bits[4:1], 4'h1);
      chk(bits[58:50], y ? 9'h027 : 9'h000);
      chk(bits[88:80], s ? 9'h155 : 9'h000);
    end
    $display("test variants done");
  endtask : t_var

  task automatic t_ext();
    tt = '0;
    tt.year_bcd = 8'h17;
    tt.sec_bcd = 7'h21;
    tt.dst = 1'b1;
    tt.dst_pend = 1'b1;
    tt.ls_pend = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) sync_ok <= 1'b1;
      frame(tt, REG_CTRL, k == 0 ? 16'h000d : (k == 1 ? 16'h0005 : 16'h0000));
      chk(mk, emk);
      chk(bits[58:50], 9'h027);
      chk(bits[63:60], 4'hd);
      chk(bits[64], k == 0);
      chk(bits[70:65], 6'h25);
      chk(bits[74:71], k == 0 ? TFOM_FAILED : TFOM_LOCKED);
      chk(bits[75], ^bits[74:0]);
    end
    rd(REG_STAT, 16'h6301);
    chk(sym_bad, 8'h00);
    chk(am_bad, 1'b0);
    chk(car_bad, 1'b0);
    $display("test extended done");
  endtask : t_ext

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    for (int i = 0; i < 100; i++) emk[i] = (i == 0) || (i % 10 == 9);
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_lw();
    t_var();
    t_ext();
    end_of_test();
  end
endmodule : ste_encoder_tb_top
